// ==== logic/apsq_map.vh ====
/*
  Constants for the conversion sequencer: register offsets, config word
  layout, modes, reset values and timing. Assumes a 20 MHz core clock.
*/
`ifndef APSQ_MAP_VH
`define APSQ_MAP_VH

`define APSQ_A_STAT    8'h00
`define APSQ_A_SINGLE  8'h04
`define APSQ_A_GROUP   8'h08
`define APSQ_A_GAP     8'h0c
`define APSQ_A_CHSET   8'h10
`define APSQ_A_TMODE   8'h14
`define APSQ_A_THR     8'h18
`define APSQ_A_PIPE    8'h1c
`define APSQ_RES_BIT   7
`define APSQ_SEL_ALL   4'hf

`define APSQ_CF_CH     4:0
`define APSQ_CF_RANGE  6:5
`define APSQ_CF_MODE   8:7
`define APSQ_CF_KIND   10:9
`define APSQ_CF_DOVAL  11
`define APSQ_CF_TAB    8:5
`define APSQ_CH_HALF   3

`define APSQ_KIND_AI   2'h0
`define APSQ_KIND_DIN  2'h1
`define APSQ_KIND_DOUT 2'h2
`define APSQ_MODE_GND  2'h0
`define APSQ_MODE_SNS  2'h1
`define APSQ_MODE_TWO  2'h2
`define APSQ_DEF_RANGE 2'h0
`define APSQ_DEF_MODE  2'h0

`define APSQ_TM_OFF    3'h0
`define APSQ_TM_BELOW  3'h1
`define APSQ_TM_ABOVE  3'h2
`define APSQ_TM_INSIDE 3'h3
`define APSQ_TM_BHYS   3'h4
`define APSQ_TM_AHYS   3'h5
`define APSQ_TM_DIN    3'h6

`define APSQ_ST_BUSY   0
`define APSQ_ST_SDONE  1
`define APSQ_ST_GDONE  2
`define APSQ_ST_VHEAD  3
`define APSQ_ST_VNEXT  4
`define APSQ_ST_REFILL 5

`define APSQ_GAP_NS    8000
`define APSQ_CLK_NS    50
`define APSQ_CNT_MAX   16'hffff
`define APSQ_CNT_ONE   16'h0001

`endif

// ==== logic/apsq_gap_timer.v ====
/*
  Spacing timer: counts cycles since the last slot start and says when
  the next slot may start. Assumes start pulses only when ready.
*/
`timescale 1ns/1ns
`include "apsq_map.vh"

module apsq_gap_timer (
  input  wire        core_clk_in,
  input  wire        srst_in,
  input  wire        start_in,
  input  wire [15:0] min_in,
  output wire        ready_out
);

  reg [15:0] cnt_q;

  // saturates so an idle converter is always ready
  always @(posedge core_clk_in) begin
    if (srst_in) begin
      cnt_q <= `APSQ_CNT_MAX;
    end else if (start_in) begin
      cnt_q <= `APSQ_CNT_ONE;
    end else if (cnt_q != `APSQ_CNT_MAX) begin
      cnt_q <= cnt_q + `APSQ_CNT_ONE;
    end
  end

  assign ready_out = (cnt_q >= min_in);

endmodule

// ==== logic/apsq_sequencer.v ====
/*
  Conversion sequencer top: Wishbone classic slave, two-stage config
  pipeline, single and grouped conversions, trigger result path.
  Assumes an external converter that pulses adc_valid_in with data after
  each conv_start_out, and an external front end that presents the
  monitored level of the channel named on trig_chan_out.
*/
`timescale 1ns/1ns
`include "apsq_map.vh"

module apsq_sequencer (
  input  wire        core_clk_in,
  input  wire        srst_in,
  input  wire        wb_cyc_in,
  input  wire        wb_stb_in,
  input  wire        wb_we_in,
  input  wire [7:0]  wb_adr_in,
  input  wire [3:0]  wb_sel_in,
  input  wire [31:0] wb_dat_in,
  output wire [31:0] wb_dat_out,
  output wire        wb_ack_out,
  output wire        conv_start_out,
  output wire [15:0] conv_cfg_out,
  input  wire        adc_valid_in,
  input  wire [15:0] adc_data_in,
  input  wire [15:0] trig_level_in,
  output wire [4:0]  trig_chan_out,
  input  wire        programmable_function_line_in,
  output wire        digital_output_line_out,
  output wire        trigger_result_out
);

  localparam [2:0]  S_IDLE  = 3'b001;
  localparam [2:0]  S_SLOT  = 3'b010;
  localparam [2:0]  S_BUSY  = 3'b100;
  localparam integer GAP_CYC = (`APSQ_GAP_NS + `APSQ_CLK_NS - 1) / `APSQ_CLK_NS;
  localparam [15:0]  GAP_RST = GAP_CYC[15:0];

  reg  [2:0]  st_q;
  reg         ack_q;
  reg  [31:0] dat_q;
  reg  [15:0] head_q;
  reg  [15:0] next_q;
  reg         vhead_q;
  reg         vnext_q;
  reg         single_q;
  reg  [15:0] scfg_q;
  reg  [15:0] sres_q;
  reg  [1:0]  refill_q;
  reg  [31:0] mask_q;
  reg  [4:0]  feed_ch_q;
  reg  [4:0]  hi_ch_q;
  reg         sdone_q;
  reg         gdone_q;
  reg  [15:0] gap_q;
  reg  [2:0]  tmode_q;
  reg  [15:0] thr_hi_q;
  reg  [15:0] thr_lo_q;
  reg         arm_q;
  reg         trig_q;
  reg         dout_q;
  reg         start_q;
  reg  [15:0] ccfg_q;
  reg  [4:0]  tch_q;
  reg  [3:0]  tab_q [0:31];
  reg  [15:0] gres_q [0:31];
  reg  [31:0] rd_d;

  wire        tmr_ready;
  wire        wb_req = wb_cyc_in & wb_stb_in & ~ack_q;
  wire        wb_wr  = wb_cyc_in & wb_stb_in & ack_q & wb_we_in & (wb_sel_in == `APSQ_SEL_ALL);
  wire        idle   = st_q[0];
  wire        wr_sgl = wb_wr & (wb_adr_in == `APSQ_A_SINGLE) & idle;
  wire        wr_grp = wb_wr & (wb_adr_in == `APSQ_A_GROUP) & idle & (|wb_dat_in);
  wire        wr_tm  = wb_wr & (wb_adr_in == `APSQ_A_TMODE);
  wire        wr_st  = wb_wr & (wb_adr_in == `APSQ_A_STAT);

  // channel list walk: lowest set bit above p, else wrap to the lowest
  function [4:0] apsq_next;
    input [31:0] m;
    input [4:0]  p;
    integer      i;
    reg   [4:0]  up;
    reg   [4:0]  lo;
    reg          hit;
    begin
      up  = 5'h00;
      lo  = 5'h00;
      hit = 1'b0;
      for (i = 31; i >= 0; i = i - 1) begin
        if (m[i]) begin
          lo = i[4:0];
          if (i[4:0] > p) begin
            up  = i[4:0];
            hit = 1'b1;
          end
        end
      end
      apsq_next = hit ? up : lo;
    end
  endfunction

  function [4:0] apsq_high;
    input [31:0] m;
    integer      i;
    begin
      apsq_high = 5'h00;
      for (i = 0; i < 32; i = i + 1) begin
        if (m[i]) begin
          apsq_high = i[4:0];
        end
      end
    end
  endfunction

  // two-wire only on the lower half of each bank of sixteen
  function [15:0] apsq_fix;
    input [15:0] c;
    begin
      apsq_fix = c;
      if ((c[`APSQ_CF_MODE] == `APSQ_MODE_TWO && c[`APSQ_CH_HALF]) ||
          (c[`APSQ_CF_MODE] > `APSQ_MODE_TWO)) begin
        apsq_fix[`APSQ_CF_MODE] = `APSQ_MODE_GND;
      end
    end
  endfunction

  function [15:0] apsq_cfg;
    input [4:0] ch;
    input [3:0] t;
    begin
      apsq_cfg = {5'h00, `APSQ_KIND_AI, t, ch};
    end
  endfunction

  // group head decision, made at the start write
  wire [4:0]  g_first  = apsq_next(wb_dat_in, 5'h1f);
  wire [4:0]  g_second = apsq_next(wb_dat_in, g_first);
  wire [4:0]  g_third  = apsq_next(wb_dat_in, g_second);
  wire        g_match  = vhead_q & vnext_q &
                         (head_q == apsq_cfg(g_first, tab_q[g_first])) &
                         (next_q == apsq_cfg(g_second, tab_q[g_second]));

  // slot completion
  wire [1:0]  kind    = head_q[`APSQ_CF_KIND];
  wire        is_ai   = (kind != `APSQ_KIND_DIN) & (kind != `APSQ_KIND_DOUT);
  wire        slot_go = st_q[1] & tmr_ready;
  wire        fin     = (slot_go & ~is_ai) | (st_q[2] & adc_valid_in);
  wire [15:0] res     = st_q[2] ? adc_data_in :
                        ((kind == `APSQ_KIND_DIN) ? {15'h0000, programmable_function_line_in} : 16'h0000);
  wire [15:0] feed    = single_q ? scfg_q : apsq_cfg(feed_ch_q, tab_q[feed_ch_q]);
  wire        res_we  = fin & ~single_q & (refill_q == 2'h0);

  apsq_gap_timer u_gap (
    .core_clk_in (core_clk_in),
    .srst_in     (srst_in),
    .start_in    (slot_go),
    .min_in      (gap_q),
    .ready_out   (tmr_ready)
  );

  // per-channel range and mode table, build defaults at reset
  genvar g;
  generate
    for (g = 0; g < 32; g = g + 1) begin : chan
      // channel field equals g whenever this entry is written
      wire [15:0] want = apsq_fix({7'h00, wb_dat_in[`APSQ_CF_TAB], wb_dat_in[`APSQ_CF_CH]});
      always @(posedge core_clk_in) begin
        if (srst_in) begin
          tab_q[g] <= {`APSQ_DEF_MODE, `APSQ_DEF_RANGE};
        end else if (wb_wr & (wb_adr_in == `APSQ_A_CHSET) & (wb_dat_in[`APSQ_CF_CH] == g)) begin
          tab_q[g] <= want[`APSQ_CF_TAB];
        end
      end
      always @(posedge core_clk_in) begin
        if (res_we & (head_q[`APSQ_CF_CH] == g)) begin
          gres_q[g] <= res;
        end
      end
    end
  endgenerate

  // sequencing state machine
  always @(posedge core_clk_in) begin
    if (srst_in) begin
      st_q      <= S_IDLE;
      head_q    <= 16'h0000;
      next_q    <= 16'h0000;
      vhead_q   <= 1'b0;
      vnext_q   <= 1'b0;
      single_q  <= 1'b0;
      scfg_q    <= 16'h0000;
      sres_q    <= 16'h0000;
      refill_q  <= 2'h0;
      mask_q    <= 32'h00000000;
      feed_ch_q <= 5'h00;
      hi_ch_q   <= 5'h00;
      dout_q    <= 1'b0;
      start_q   <= 1'b0;
      ccfg_q    <= 16'h0000;
    end else begin
      start_q <= 1'b0;
      case (st_q)
        S_IDLE: begin
          if (wr_sgl) begin
            single_q <= 1'b1;
            scfg_q   <= wb_dat_in[15:0];
            refill_q <= 2'h0;
            st_q     <= S_SLOT;
          end else if (wr_grp) begin
            single_q <= 1'b0;
            mask_q   <= wb_dat_in;
            hi_ch_q  <= apsq_high(wb_dat_in);
            st_q     <= S_SLOT;
            if (g_match) begin
              refill_q  <= 2'h0;
              feed_ch_q <= g_third;
            end else begin
              refill_q  <= 2'h2;
              feed_ch_q <= g_first;
            end
          end
        end
        S_SLOT: begin
          if (slot_go & is_ai) begin
            start_q <= 1'b1;
            ccfg_q  <= apsq_fix(head_q);
            st_q    <= S_BUSY;
          end
        end
        S_BUSY: begin
          st_q <= S_BUSY;
        end
        default: begin
          st_q <= S_IDLE;
        end
      endcase
      if (fin) begin
        // convert head first, then shift the new config behind it
        head_q  <= next_q;
        vhead_q <= vnext_q;
        next_q  <= feed;
        vnext_q <= 1'b1;
        if (kind == `APSQ_KIND_DOUT) begin
          dout_q <= head_q[`APSQ_CF_DOVAL];
        end
        if (single_q) begin
          sres_q <= res;
          st_q   <= S_IDLE;
        end else begin
          feed_ch_q <= apsq_next(mask_q, feed_ch_q);
          if (refill_q != 2'h0) begin
            refill_q <= refill_q - 2'h1;
            st_q     <= S_SLOT;
          end else if (head_q[`APSQ_CF_CH] == hi_ch_q) begin
            st_q <= S_IDLE;
          end else begin
            st_q <= S_SLOT;
          end
        end
      end
    end
  end

  // sticky done flags; a set in the clearing cycle wins
  wire sdone_set = fin & single_q;
  wire gdone_set = res_we & (head_q[`APSQ_CF_CH] == hi_ch_q);

  always @(posedge core_clk_in) begin
    if (srst_in) begin
      sdone_q  <= 1'b0;
      gdone_q  <= 1'b0;
      gap_q    <= GAP_RST;
      tmode_q  <= `APSQ_TM_OFF;
      thr_hi_q <= 16'h0000;
      thr_lo_q <= 16'h0000;
    end else begin
      sdone_q <= sdone_set | (sdone_q & ~(wr_st & wb_dat_in[`APSQ_ST_SDONE]));
      gdone_q <= gdone_set | (gdone_q & ~(wr_st & wb_dat_in[`APSQ_ST_GDONE]));
      if (wb_wr & (wb_adr_in == `APSQ_A_GAP)) begin
        gap_q <= wb_dat_in[15:0];
      end
      if (wr_tm) begin
        tmode_q <= wb_dat_in[2:0];
      end
      if (wb_wr & (wb_adr_in == `APSQ_A_THR)) begin
        thr_hi_q <= wb_dat_in[31:16];
        thr_lo_q <= wb_dat_in[15:0];
      end
    end
  end

  // trigger circuitry; output only, never starts a slot
  wire lt_lo = $signed(trig_level_in) < $signed(thr_lo_q);
  wire gt_hi = $signed(trig_level_in) > $signed(thr_hi_q);

  always @(posedge core_clk_in) begin
    if (srst_in | wr_tm) begin
      trig_q <= 1'b0;
      arm_q  <= 1'b0;
      tch_q  <= 5'h00;
    end else begin
      tch_q <= head_q[`APSQ_CF_CH];
      case (tmode_q)
        `APSQ_TM_BELOW: trig_q <= lt_lo;
        `APSQ_TM_ABOVE: trig_q <= gt_hi;
        `APSQ_TM_INSIDE: trig_q <= ~lt_lo & ~gt_hi;
        `APSQ_TM_BHYS: begin
          if (gt_hi) begin
            arm_q  <= 1'b1;
            trig_q <= 1'b0;
          end else if (arm_q & lt_lo) begin
            trig_q <= 1'b1;
          end
        end
        `APSQ_TM_AHYS: begin
          if (lt_lo) begin
            arm_q  <= 1'b1;
            trig_q <= 1'b0;
          end else if (arm_q & gt_hi) begin
            trig_q <= 1'b1;
          end
        end
        `APSQ_TM_DIN: trig_q <= programmable_function_line_in;
        default: trig_q <= 1'b0;
      endcase
    end
  end

  // read mux; trigger readout bypasses the pipeline
  always @* begin
    rd_d = 32'h00000000;
    if (wb_adr_in[`APSQ_RES_BIT]) begin
      rd_d = {16'h0000, gres_q[wb_adr_in[6:2]]};
    end else begin
      case (wb_adr_in)
        `APSQ_A_STAT: begin
          rd_d[`APSQ_ST_BUSY]   = ~idle;
          rd_d[`APSQ_ST_SDONE]  = sdone_q;
          rd_d[`APSQ_ST_GDONE]  = gdone_q;
          rd_d[`APSQ_ST_VHEAD]  = vhead_q;
          rd_d[`APSQ_ST_VNEXT]  = vnext_q;
          rd_d[`APSQ_ST_REFILL] = (refill_q != 2'h0);
        end
        `APSQ_A_SINGLE: rd_d = {16'h0000, sres_q};
        `APSQ_A_GROUP:  rd_d = mask_q;
        `APSQ_A_GAP:    rd_d = {16'h0000, gap_q};
        `APSQ_A_TMODE:  rd_d = {27'h0000000, trig_q, 1'b0, tmode_q};
        `APSQ_A_THR:    rd_d = {thr_hi_q, thr_lo_q};
        `APSQ_A_PIPE:   rd_d = {next_q, head_q};
        default:        rd_d = 32'h00000000;
      endcase
    end
  end

  // ack one cycle after the request, dropped the cycle after
  always @(posedge core_clk_in) begin
    if (srst_in) begin
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
    end else begin
      ack_q <= wb_req;
      if (wb_req) begin
        dat_q <= rd_d;
      end
    end
  end

  assign wb_dat_out              = dat_q;
  assign wb_ack_out              = ack_q;
  assign conv_start_out          = start_q;
  assign conv_cfg_out            = ccfg_q;
  assign trig_chan_out           = tch_q;
  assign digital_output_line_out = dout_q;
  assign trigger_result_out      = trig_q;

endmodule

// ==== verif/apsq_conv_model.sv ====
/*
  Converter stand-in on the sequencer's conversion link.
  Assumes lat_in >= 1; answers each start pulse after lat_in cycles.
*/
`timescale 1ns/1ns
module apsq_conv_model (
  input  wire         clk_in,
  input  wire         srst_in,
  input  wire         start_in,
  input  wire  [15:0] cfg_in,
  input  wire  [7:0]  lat_in,
  output logic        valid_out,
  output logic [15:0] data_out
);
  logic [7:0]  cnt_q;
  logic [15:0] cfg_q;
  // data toggles outside the answer cycle so stale values never match
  always @(posedge clk_in) begin
    valid_out <= 1'b0;
    data_out  <= ~data_out;
    if (srst_in) begin
      cnt_q    <= 8'h00;
      data_out <= 16'h0f0f;
    end else if (start_in) begin
      cnt_q <= lat_in;
      cfg_q <= cfg_in;
    end else if (cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
      if (cnt_q == 8'h01) begin
        valid_out <= 1'b1;
        data_out  <= {cfg_q[8:0], 7'h2a};
      end
    end
  end
endmodule

// ==== verif/apsq_sequencer_chk.sv ====
/*
  Port checker for the sequencer, bound at the foot.
  Assumes register writes take effect at the acked edge.
*/
`timescale 1ns/1ns
`include "apsq_map.vh"
module apsq_sequencer_chk (
  input wire        core_clk_in,
  input wire        srst_in,
  input wire        wb_cyc_in,
  input wire        wb_stb_in,
  input wire        wb_we_in,
  input wire [7:0]  wb_adr_in,
  input wire [3:0]  wb_sel_in,
  input wire [31:0] wb_dat_in,
  input wire        wb_ack_out,
  input wire        conv_start_out,
  input wire [15:0] conv_cfg_out,
  input wire        programmable_function_line_in,
  input wire        trigger_result_out
);
  wire        wr = wb_cyc_in & wb_stb_in & wb_we_in & wb_ack_out & (wb_sel_in == 4'hf);
  reg  [15:0] gap_q;
  reg  [15:0] cnt_q;
  reg  [2:0]  tm_q;
  reg         req_q;
  // shadow of spacing, trigger mode and first request
  always @(posedge core_clk_in) begin
    if (srst_in) begin
      gap_q <= 16'h00a0;
      cnt_q <= 16'hffff;
      tm_q  <= 3'h0;
      req_q <= 1'b0;
    end else begin
      if (conv_start_out)
        cnt_q <= 16'h0001;
      else if (cnt_q != 16'hffff)
        cnt_q <= cnt_q + 16'h0001;
      if (wr && wb_adr_in == `APSQ_A_GAP)
        gap_q <= wb_dat_in[15:0];
      if (wr && wb_adr_in == `APSQ_A_TMODE)
        tm_q <= wb_dat_in[2:0];
      if (wr && (wb_adr_in == `APSQ_A_SINGLE || wb_adr_in == `APSQ_A_GROUP))
        req_q <= 1'b1;
    end
  end
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);
  start_pulse_a: assert property (
    conv_start_out |=> !conv_start_out) else $error("start pulse too long");
  gap_space_a: assert property (
    conv_start_out |-> cnt_q >= gap_q) else $error("conversions closer than the gap");
  cfg_hold_a: assert property (
    $changed(conv_cfg_out) |-> conv_start_out) else $error("config moved without a start");
  two_wire_a: assert property (
    conv_start_out && conv_cfg_out[`APSQ_CF_MODE] == `APSQ_MODE_TWO |-> !conv_cfg_out[`APSQ_CH_HALF])
    else $error("two-wire on a disallowed channel");
  digital_slot_a: assert property (
    conv_start_out |-> conv_cfg_out[`APSQ_CF_KIND] != `APSQ_KIND_DIN && conv_cfg_out[`APSQ_CF_KIND] != `APSQ_KIND_DOUT)
    else $error("digital slot started the converter");
  no_self_start_a: assert property (
    conv_start_out |-> req_q) else $error("start without any request");
  trig_off_a: assert property (
    tm_q == `APSQ_TM_OFF |-> !trigger_result_out) else $error("trigger set while off");
  trig_din_a: assert property (
    tm_q == `APSQ_TM_DIN && $past(tm_q) == `APSQ_TM_DIN |-> trigger_result_out == $past(programmable_function_line_in))
    else $error("trigger does not follow the function line");
endmodule

bind apsq_sequencer apsq_sequencer_chk chk (
  .core_clk_in, .srst_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in,
  .wb_ack_out, .conv_start_out, .conv_cfg_out, .programmable_function_line_in, .trigger_result_out
);

// ==== verif/tb_adc_pipeline_sequencer.sv ====
/*
  Self-checking bench for the sequencer: Wishbone master, pipeline model,
  converter stand-in. Assumes the register map of apsq_map.vh.
*/
`timescale 1ns/1ns
`include "apsq_map.vh"
module tb_adc_pipeline_sequencer;
  logic        clk, srst, cyc, stb, we, pfl, dv, ack, cst, dout, trg;
  logic [7:0]  adr, lat;
  logic [3:0]  sel;
  logic [31:0] wdat, dbus, rd, mask;
  logic [15:0] ccfg, adat, lvl, tab [32];
  logic [4:0]  tch;
  logic [15:0] pq[$], scfg[$];
  int          num_errors, checks, cyc_n, starts[$];

  apsq_sequencer uut (
    .core_clk_in(clk), .srst_in(srst), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
    .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(dbus), .wb_ack_out(ack),
    .conv_start_out(cst), .conv_cfg_out(ccfg), .adc_valid_in(dv), .adc_data_in(adat),
    .trig_level_in(lvl), .trig_chan_out(tch), .programmable_function_line_in(pfl),
    .digital_output_line_out(dout), .trigger_result_out(trg));
  apsq_conv_model conv (
    .clk_in(clk), .srst_in(srst), .start_in(cst), .cfg_in(ccfg), .lat_in(lat),
    .valid_out(dv), .data_out(adat));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (cst === 1'b1) begin
      starts.push_back(cyc_n);
      scfg.push_back(ccfg);
    end
    if (cyc_n == 60000) begin
      num_errors++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= s;
    do @(posedge clk); while (ack !== 1'b1);
    rd = dbus;
    cyc <= 1'b0; stb <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0, 4'hf);
    chk(nm, e, rd);
  endtask
  task automatic waitst(input int b);
    int n;
    n = 0;
    do begin
      bus(1'b0, `APSQ_A_STAT, 32'h0, 4'hf);
      n++;
    end while (rd[b] !== 1'b1 && n < 400);
    chk("status done", 32'h1, rd[b]);
    bus(1'b1, `APSQ_A_STAT, 32'h1 << b, 4'hf);
  endtask
  function automatic logic [15:0] adj(input logic [15:0] c);
    if (c[8:7] == 2'h3 || (c[8:7] == 2'h2 && c[3]))
      c[8:7] = 2'h0;
    return c;
  endfunction
  task automatic single(input logic [15:0] c);
    logic [15:0] h, a;
    int n0;
    h = pq.pop_front();
    a = adj(h);
    pq.push_back(c);
    n0 = starts.size();
    pfl <= 1'($urandom);
    bus(1'b1, `APSQ_A_SINGLE, {16'h0, c}, 4'hf);
    waitst(`APSQ_ST_SDONE);
    bus(1'b0, `APSQ_A_SINGLE, 32'h0, 4'hf);
    if (h[10:9] == `APSQ_KIND_DIN) begin
      chk("din result", {31'h0, pfl}, rd);
      chk("din starts", n0, starts.size());
    end else if (h[10:9] == `APSQ_KIND_DOUT) begin
      chk("dout line", h[11], dout);
      chk("dout starts", n0, starts.size());
    end else begin
      chk("single cfg", a, scfg[scfg.size()-1]);
      chk("single result", {a[8:0], 7'h2a}, rd);
    end
  endtask
  task automatic grp(input int xtra);
    int n0, i, k;
    logic [4:0] ch[$];
    n0 = starts.size();
    for (i = 0; i < 32; i++)
      if (mask[i])
        ch.push_back(5'(i));
    bus(1'b1, `APSQ_A_GROUP, mask, 4'hf);
    waitst(`APSQ_ST_GDONE);
    if (xtra >= 0)
      chk("group starts", ch.size() + xtra, starts.size() - n0);
    for (k = 0; k < ch.size(); k++) begin
      i = starts.size() - ch.size() + k;
      chk("group order", tab[ch[k]], scfg[i]);
      if (k > 0 && lat < 8'h06)
        chk("group spacing", 32'h6, starts[i] - starts[i-1]);
      bus(1'b0, {1'b1, ch[k], 2'h0}, 32'h0, 4'hf);
      chk("group result", {tab[ch[k]][8:0], 7'h2a}, rd);
    end
    rchk(`APSQ_A_PIPE, {tab[ch[1]], tab[ch[0]]}, "pipe kept");
    pq.delete();
    pq.push_back(tab[ch[0]]);
    pq.push_back(tab[ch[1]]);
  endtask

  initial begin
    int k, m, n, lv[5];
    logic [15:0] c;
    logic t, arm;
    srst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'h0; wdat = 32'h0;
    pfl = 1'b0; lvl = 16'h0000; lat = 8'h02; num_errors = 0; checks = 0; cyc_n = 0;
    lv = '{500, -500, 0, 500, -500};
    k = $urandom(32'hbc4c39b5);
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    rchk(`APSQ_A_STAT, 32'h0, "stat reset");
    rchk(`APSQ_A_GAP, 32'ha0, "gap reset");
    rchk(`APSQ_A_PIPE, 32'h0, "pipe reset");
    rchk(8'h40, 32'h0, "unmapped read");
    bus(1'b1, `APSQ_A_GAP, 32'h3, 4'h3);
    rchk(`APSQ_A_GAP, 32'ha0, "gap partial write");
    bus(1'b1, `APSQ_A_GAP, 32'h6, 4'hf);
    mask = ($urandom & $urandom) | 32'h80000010;
    for (k = 0; k < 32; k++)
      if (mask[k]) begin
        c = {7'h0, 2'($urandom), 2'($urandom), 5'(k)};
        tab[k] = adj(c);
        bus(1'b1, `APSQ_A_CHSET, {16'h0, c}, 4'hf);
      end
    grp(-1);
    for (k = 0; k < 18; k++) begin
      c = (k == 3) ? 16'h0109 : $urandom & 16'h0fff;
      if (k > 15)
        c = 16'h0600 | (c & 16'h007f);
      single(c);
    end
    grp(2);
    lat = 8'h09;
    grp(0);
    bus(1'b1, `APSQ_A_THR, 32'h0064ff9c, 4'hf);
    bus(1'b0, `APSQ_A_PIPE, 32'h0, 4'hf);
    chk("pipe before trigger", {pq[1], pq[0]}, rd);
    chk("trigger channel", {27'h0, pq[0][4:0]}, tch);
    n = starts.size();
    for (m = 0; m < 7; m++) begin
      lvl <= 16'h0000;
      bus(1'b1, `APSQ_A_TMODE, m, 4'hf);
      arm = 1'b0;
      t = 1'b0;
      for (k = 0; k < 5; k++) begin
        lvl <= 16'(lv[k]);
        pfl <= k[0];
        repeat (4) @(posedge clk);
        case (m)
          1: t = lv[k] < -100;
          2: t = lv[k] > 100;
          3: t = lv[k] > -100 && lv[k] < 100;
          4: if (lv[k] > 100) begin t = 1'b0; arm = 1'b1; end else if (arm && lv[k] < -100) t = 1'b1;
          5: if (lv[k] < -100) begin t = 1'b0; arm = 1'b1; end else if (arm && lv[k] > 100) t = 1'b1;
          6: t = k[0];
          default: t = 1'b0;
        endcase
        chk("trigger line", t, trg);
        rchk(`APSQ_A_TMODE, {27'h0, t, 1'b0, 3'(m)}, "trigger reg");
      end
    end
    rchk(`APSQ_A_PIPE, {pq[1], pq[0]}, "pipe untouched");
    chk("no self start", n, starts.size());
    // triggered acquisition: poll the trigger bit, then request
    pfl <= 1'b1;
    n = 0;
    do begin
      bus(1'b0, `APSQ_A_TMODE, 32'h0, 4'hf);
      n++;
    end while (rd[4] !== 1'b1 && n < 20);
    chk("trigger seen", 32'h1, rd[4]);
    single(16'h0005);
    complete_run();
  end
endmodule
